/* rtl/vbc_pkg.sv */
// package: offsets, reset values, field positions and carriers for the bridge header
`default_nettype none
package vbc_pkg;
  localparam logic [7:0] OFS_STATUS = 8'h06;
  localparam logic [7:0] OFS_REVISION = 8'h08;
  localparam logic [7:0] OFS_SUB_CLASS = 8'h0a;
  localparam logic [7:0] OFS_BASE_CLASS = 8'h0b;
  localparam logic [7:0] OFS_LATENCY = 8'h0d;
  localparam logic [7:0] OFS_HEADER = 8'h0e;
  localparam logic [7:0] OFS_UP_BUS = 8'h18;
  localparam logic [7:0] OFS_DOWN_BUS = 8'h19;
  localparam logic [7:0] OFS_HIGH_BUS = 8'h1a;
  localparam logic [7:0] OFS_COMMAND = 8'h04;

  localparam logic [15:0] STATUS_RESET = 16'h00a0;
  localparam logic [7:0] SUB_CLASS_VAL = 8'h04;
  localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
  localparam logic [7:0] HEADER_VAL = 8'h01;
  localparam logic [7:0] UP_BUS_VAL = 8'h00;
  localparam logic [7:0] BUS_RESET = 8'h00;
  localparam logic [4:0] LATENCY_RESET = 5'h00;

  localparam int STS_SYS_ERR_BIT = 14;
  localparam int STS_FAST_BUS_BIT = 5;
  localparam int STS_B2B_BIT = 7;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int LAT_LSB = 3;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } vbc_cfg_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } vbc_cfg_rsp_s;
endpackage : vbc_pkg
`default_nettype wire

/* rtl/vbc_status_flag.sv */
// sticky write-one-to-clear flag where a new event wins over the clear
`default_nettype none
module vbc_status_flag (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);
  logic flag_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clear_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;
endmodule : vbc_status_flag
`default_nettype wire

/* rtl/vbc_byte_reg.sv */
// byte-wide writable register with a write mask for reserved bits
`default_nettype none
module vbc_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] value_o
);
  logic [7:0] value_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      value_q <= RESET_VAL;
    end else if (we_i) begin
      value_q <= wdata_i & WMASK;
    end
  end

  assign value_o = value_q;
endmodule : vbc_byte_reg
`default_nettype wire

/* rtl/vbc_config_header.sv */
// configuration header registers of the virtual bridge function
`default_nettype none
// Contract
// - status bits 15 and 8 always read zero; no parity checking.
// - status bit 14 sets on a sent system-error message, cleared by writing one.
// - status bits 13, 12, 11 are constant zero.
// - status bits 10:9 read 00, fastest decode.
// - status bit 7 always reads one.
// - status bit 5 always reads one.
// - revision at 08h, read-only, equals the first function's revision.
// - sub-class at 0Ah reads 04h.
// - latency bits 7:3 are a scratchpad, reset zero, no other effect.
// - header type at 0Eh reads 01h, no storage.
// - primary bus number at 18h is fixed 00h.
// - secondary bus number at 19h writable, reset 00h, drives config mapping.
// - subordinate bus number at 1Ah writable, reset 00h.
// - status word at 06h is 16 bits, resets to 00A0h.
// - system-error messages go out only while command bit 8 is one.
module vbc_config_header (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire vbc_pkg::vbc_cfg_req_s cfg_req_i,
  output vbc_pkg::vbc_cfg_rsp_s cfg_rsp_o,
  input wire logic [7:0] first_fn_revision_i,
  input wire logic system_error_msg_enable_i,
  input wire logic error_event_i,
  output logic hub_link_serr_msg_o,
  output logic [7:0] downstream_bus_number_o,
  output logic [7:0] highest_bus_number_o,
  output logic [15:0] primary_status_o
);
  // ==========================================================
  // address decode
  // accesses are dword-aligned; byte lanes pick bytes within the word
  logic [7:0] word_addr;
  logic wr_status_upper;
  logic wr_latency;
  logic wr_down_bus;
  logic wr_high_bus;

  assign word_addr = {cfg_req_i.addr[7:2], 2'b00};
  assign wr_status_upper = cfg_req_i.wr && (word_addr == {vbc_pkg::OFS_COMMAND[7:2], 2'b00})
                        && cfg_req_i.be[3];
  assign wr_latency = cfg_req_i.wr && (word_addr == {vbc_pkg::OFS_LATENCY[7:2], 2'b00})
                      && cfg_req_i.be[1];
  assign wr_down_bus = cfg_req_i.wr && (word_addr == {vbc_pkg::OFS_DOWN_BUS[7:2], 2'b00})
                       && cfg_req_i.be[1];
  assign wr_high_bus = cfg_req_i.wr && (word_addr == {vbc_pkg::OFS_HIGH_BUS[7:2], 2'b00})
                       && cfg_req_i.be[2];

  // ==========================================================
  // system-error message and sticky status flag
  logic serr_msg;
  logic sys_err_flag;

  // an error with the enable clear produces no message at all
  assign serr_msg = error_event_i && system_error_msg_enable_i;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hub_link_serr_msg_o <= 1'b0;
    end else begin
      hub_link_serr_msg_o <= serr_msg;
    end
  end

  vbc_status_flag u_sys_err (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .set_i(serr_msg),
    .clear_i(wr_status_upper && cfg_req_i.wdata[16 + vbc_pkg::STS_SYS_ERR_BIT]),
    .flag_o(sys_err_flag)
  );

  // ==========================================================
  // writable bytes
  logic [7:0] latency_val;

  vbc_byte_reg #(
    .RESET_VAL({vbc_pkg::LATENCY_RESET, 3'b000}),
    .WMASK(8'hf8)
  ) u_latency (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .we_i(wr_latency),
    .wdata_i(cfg_req_i.wdata[15:8]),
    .value_o(latency_val)
  );

  vbc_byte_reg #(
    .RESET_VAL(vbc_pkg::BUS_RESET),
    .WMASK(8'hff)
  ) u_down_bus (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .we_i(wr_down_bus),
    .wdata_i(cfg_req_i.wdata[15:8]),
    .value_o(downstream_bus_number_o)
  );

  vbc_byte_reg #(
    .RESET_VAL(vbc_pkg::BUS_RESET),
    .WMASK(8'hff)
  ) u_high_bus (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .we_i(wr_high_bus),
    .wdata_i(cfg_req_i.wdata[23:16]),
    .value_o(highest_bus_number_o)
  );

  // ==========================================================
  // status word assembly
  logic [15:0] status_word;

  always_comb begin
    status_word = 16'h0000;
    status_word[vbc_pkg::STS_B2B_BIT] = 1'b1;
    status_word[vbc_pkg::STS_FAST_BUS_BIT] = 1'b1;
    status_word[vbc_pkg::STS_SYS_ERR_BIT] = sys_err_flag;
  end

  assign primary_status_o = status_word;

  // ==========================================================
  // read data, registered so it answers one cycle after the request
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (word_addr)
      {vbc_pkg::OFS_COMMAND[7:2], 2'b00}: begin
        // command half lives outside this set; only the status half is served
        rdata_d[31:16] = status_word;
      end
      {vbc_pkg::OFS_REVISION[7:2], 2'b00}: begin
        rdata_d[7:0] = first_fn_revision_i;
        rdata_d[23:16] = vbc_pkg::SUB_CLASS_VAL;
        rdata_d[31:24] = vbc_pkg::BASE_CLASS_VAL;
      end
      {vbc_pkg::OFS_LATENCY[7:2], 2'b00}: begin
        rdata_d[15:8] = latency_val;
        rdata_d[23:16] = vbc_pkg::HEADER_VAL;
      end
      {vbc_pkg::OFS_UP_BUS[7:2], 2'b00}: begin
        rdata_d[7:0] = vbc_pkg::UP_BUS_VAL;
        rdata_d[15:8] = downstream_bus_number_o;
        rdata_d[23:16] = highest_bus_number_o;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg_rsp_o <= '0;
    end else begin
      cfg_rsp_o.ack <= cfg_req_i.rd || cfg_req_i.wr;
      cfg_rsp_o.rdata <= cfg_req_i.rd ? rdata_d : 32'h0000_0000;
    end
  end
endmodule : vbc_config_header
`default_nettype wire

/* verif/vbc_config_header_sva.sv */
// checker: port assertions for the bridge header
`default_nettype none
module vbc_config_header_sva (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire vbc_pkg::vbc_cfg_req_s cfg_req_i,
  input wire vbc_pkg::vbc_cfg_rsp_s cfg_rsp_o,
  input wire logic [7:0] first_fn_revision_i,
  input wire logic system_error_msg_enable_i,
  input wire logic error_event_i,
  input wire logic hub_link_serr_msg_o,
  input wire logic [7:0] downstream_bus_number_o,
  input wire logic [7:0] highest_bus_number_o,
  input wire logic [15:0] primary_status_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire err_en = error_event_i && system_error_msg_enable_i;
  // a clear needs the top byte lane enabled
  wire clr = cfg_req_i.wr && cfg_req_i.addr[7:2] == 6'h01 && cfg_req_i.be[3] && cfg_req_i.wdata[30];
  // ==========
  // assertions
  chk_parity_bits_zero: assert property (!primary_status_o[15] && !primary_status_o[8])
    else $error("parity bits set");
  chk_abort_decode_zero: assert property (primary_status_o[13:9] == 5'h00)
    else $error("abort or decode bits set");
  chk_low_byte_fixed: assert property (primary_status_o[7:0] == 8'ha0)
    else $error("status low byte wrong");
  chk_serr_on_event: assert property (err_en |=> hub_link_serr_msg_o && primary_status_o[14])
    else $error("no message after enabled event");
  chk_serr_needs_enable: assert property (!err_en |=> !hub_link_serr_msg_o)
    else $error("message without enabled event");
  chk_sys_err_sticky: assert property (primary_status_o[14] && !clr |=> primary_status_o[14])
    else $error("sticky bit lost");
  chk_sys_err_clears: assert property (clr && !err_en |=> !primary_status_o[14])
    else $error("sticky bit not cleared");
  chk_class_read: assert property (cfg_req_i.rd && cfg_req_i.addr[7:2] == 6'h02 |=>
    cfg_rsp_o.rdata[31:16] == 16'h0604 && cfg_rsp_o.rdata[7:0] == $past(first_fn_revision_i))
    else $error("class or revision read wrong");
  chk_down_bus_write: assert property (cfg_req_i.wr && cfg_req_i.addr[7:2] == 6'h06 && cfg_req_i.be[1] |=>
    downstream_bus_number_o == $past(cfg_req_i.wdata[15:8])) else $error("bus number not written");
endmodule : vbc_config_header_sva
`default_nettype wire

/* verif/testbench.sv */
// testbench: register access scenarios for the bridge header
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  vbc_pkg::vbc_cfg_req_s req = '0;
  vbc_pkg::vbc_cfg_rsp_s rsp;
  logic [7:0] rev = 8'h3c;
  logic en = 1'b0;
  logic ev = 1'b0;
  logic serr;
  logic [7:0] dbus, hbus;
  logic [15:0] sts;
  logic [31:0] rdata_seen = 32'h0000_0000;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clock_i = ~clock_i;
  vbc_config_header dut (.clock_i(clock_i), .rst_i(rst_i), .cfg_req_i(req), .cfg_rsp_o(rsp),
    .first_fn_revision_i(rev), .system_error_msg_enable_i(en), .error_event_i(ev), .hub_link_serr_msg_o(serr),
    .downstream_bus_number_o(dbus), .highest_bus_number_o(hbus), .primary_status_o(sts));
  // ==========
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // one-cycle request; ack and read data stand only in the following cycle, so they are taken there
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    req <= '{rd: !w, wr: w, addr: a, be: be, wdata: d};
    @(negedge clock_i);
    check("ack", {31'h0, rsp.ack}, 32'h1);
    rdata_seen = rsp.rdata;
    req <= '0;
    @(negedge clock_i);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    acc(1'b0, a, 4'hf, 32'h0);
    check("rdata", rdata_seen & m, exp);
  endtask : rd
  task automatic fire(input logic e, input logic c);
    en <= e;
    ev <= 1'b1;
    req <= '{rd: 1'b0, wr: c, addr: 8'h04, be: 4'h8, wdata: 32'h40000000};
    @(negedge clock_i);
    ev <= 1'b0;
    req <= '0;
    check("serr", {31'h0, serr}, {31'h0, e});
    // let an edge pass so the next call never drives the strobes twice in one step
    @(negedge clock_i);
  endtask : fire
  // ==========
  // sequence
  initial begin
    repeat (12) @(negedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    check("sts", {16'h0, sts}, 32'ha0);
    rd(8'h04, 32'hffff0000, 32'h00a00000);
    rd(8'h08, 32'hffff00ff, 32'h0604003c);
    rev <= 8'h5a;
    rd(8'h08, 32'hff, 32'h5a);
    rd(8'h0c, 32'hffff00, 32'h10000);
    acc(1'b1, 8'h0c, 4'hf, 32'hffffffff);
    rd(8'h0c, 32'hffff00, 32'h1f800);
    acc(1'b1, 8'h18, 4'hf, 32'hffff0705);
    rd(8'h18, 32'hffffff, 32'hff0700);
    acc(1'b1, 8'h18, 4'h4, 32'h330000);
    check("bus", {16'h0, hbus, dbus}, 32'h3307);
    acc(1'b1, 8'h04, 4'hc, 32'hbfff0000);
    check("sts", {16'h0, sts}, 32'ha0);
    fire(1'b0, 1'b0);
    check("sts", {16'h0, sts}, 32'ha0);
    fire(1'b1, 1'b0);
    acc(1'b1, 8'h04, 4'hc, 32'hbfff0000);
    check("sts", {16'h0, sts}, 32'h40a0);
    acc(1'b1, 8'h04, 4'h8, 32'h40000000);
    check("sts", {16'h0, sts}, 32'ha0);
    fire(1'b1, 1'b1);
    check("sts", {16'h0, sts}, 32'h40a0);
    rd(8'h20, 32'hffffffff, 32'h0);
    rst_i <= 1'b1;
    @(negedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    check("bus", {16'h0, hbus, dbus}, 32'h0);
    check("sts", {16'h0, sts}, 32'ha0);
    tally_and_finish();
  end
  // the sequence needs well under a hundred cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
endmodule : testbench
bind vbc_config_header vbc_config_header_sva chk (.clock_i(clock_i), .rst_i(rst_i), .cfg_req_i(cfg_req_i),
  .cfg_rsp_o(cfg_rsp_o), .first_fn_revision_i(first_fn_revision_i), .error_event_i(error_event_i),
  .system_error_msg_enable_i(system_error_msg_enable_i), .hub_link_serr_msg_o(hub_link_serr_msg_o),
  .downstream_bus_number_o(downstream_bus_number_o), .highest_bus_number_o(highest_bus_number_o),
  .primary_status_o(primary_status_o));
`default_nettype wire
